// ### pkg/ptr_cfg.svh
// constants for the pixel token readout control block
`ifndef PTR_CFG_SVH
`define PTR_CFG_SVH

`define PTR_CLUSTERS        8
`define PTR_PIXELS          2760
`define PTR_TOKEN_ELEM      0
`define PTR_CLK_PERIOD_NS   40
`define PTR_SETTLE_NS       100
`define PTR_SETTLE_CYC      \
    ((`PTR_SETTLE_NS + `PTR_CLK_PERIOD_NS - 1) / `PTR_CLK_PERIOD_NS)
`define PTR_PEAK_US         10
`define PTR_PEAK_CYC        ((`PTR_PEAK_US * 1000) / `PTR_CLK_PERIOD_NS)

`endif

// ### pkg/ptr_pkg.sv
// types for the pixel token readout control block
package ptr_pkg;

    typedef enum logic [2:0] {
        PTR_TRACK = 3'b001,
        PTR_PEAK  = 3'b010,
        PTR_HOLD  = 3'b100
    } ptr_hold_state_t;

endpackage : ptr_pkg

// ### verilog/ptr_readout_ctrl.sv
// pixel matrix readout control: peak/hold, token chain, sample buffer
`timescale 1ns/100ps
`include "ptr_cfg.svh"

module ptr_readout_ctrl #(
    parameter int CLUSTERS = `PTR_CLUSTERS,
    parameter int PIXELS   = `PTR_PIXELS,
    parameter int IW       = $clog2(PIXELS + 2)
) (
    input  wire logic                clk_sys,
    input  wire logic                srst,
    input  wire logic                ce,
    input  wire logic                chain_reset,
    input  wire logic                reg_clk,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic                multi_token_fill,
    input  wire logic                peak_hold_cmd,
    input  wire logic                self_trigger_enable,
    input  wire logic                analog_memory_clear,
    input  wire logic [CLUSTERS-1:0] cluster_over_threshold,
    output logic      [CLUSTERS-1:0] cluster_trigger_n,
    output logic      [CLUSTERS-1:0] last_pixel_flag,
    output logic      [PIXELS:0]     token_map,
    output logic                     bus_connect,
    output logic                     live_view,
    output logic                     inject_strobe,
    output logic                     peak_detect,
    output logic                     hold,
    output logic                     sample_valid,
    output logic      [IW-1:0]       sample_index,
    input  wire logic                sample_ready
);

    localparam int NP = 8 + CLUSTERS;
    localparam logic [7:0] SETTLE_CYC = 8'(`PTR_SETTLE_CYC);
    localparam logic [15:0] PEAK_CYC = 16'(`PTR_PEAK_CYC);
    localparam logic [PIXELS:0] TOKEN_LOAD =
        (PIXELS+1)'(1) << `PTR_TOKEN_ELEM;
    localparam logic [IW-1:0] POS_MAX = IW'(PIXELS + 1);
    localparam logic [IW-1:0] POS_LAST = IW'(PIXELS);

    // two-flop synchronisers for every input pin except clk_sys, srst, ce and sample_ready
    logic [NP-1:0] sync1_q;
    logic [NP-1:0] sync2_q;
    logic [NP-1:0] prev_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            prev_q  <= '0;
        end else if (ce) begin
            sync1_q <= {cluster_over_threshold, analog_memory_clear,
                        self_trigger_enable, peak_hold_cmd,
                        multi_token_fill, write, read, reg_clk,
                        chain_reset};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    wire                s_reset    = sync2_q[0];
    wire                s_clk      = sync2_q[1];
    wire                s_read     = sync2_q[2];
    wire                s_write    = sync2_q[3];
    wire                s_fill     = sync2_q[4];
    wire                s_hold_cmd = sync2_q[5];
    wire                s_self_en  = sync2_q[6];
    wire                s_clear    = sync2_q[7];
    wire [CLUSTERS-1:0] s_over     = sync2_q[NP-1:8];
    wire                clk_fall   = prev_q[1] & ~s_clk;
    wire                write_rise = ~prev_q[3] & s_write;
    wire                any_over   = |s_over;

    // token chain, one copy shared by all clusters
    logic [PIXELS:0] chain_q;
    logic [PIXELS:0] chain_d;
    logic [IW-1:0]   pos_q;
    logic [IW-1:0]   pos_d;

    assign chain_d = s_reset  ? TOKEN_LOAD :
                     clk_fall ? {chain_q[PIXELS-1:0], s_fill}
                              : chain_q;
    assign pos_d   = s_reset ? '0 :
                     (clk_fall && pos_q != POS_MAX) ? pos_q + IW'(1) : pos_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            chain_q <= TOKEN_LOAD;
            pos_q   <= '0;
        end else if (ce) begin
            chain_q <= chain_d;
            pos_q   <= pos_d;
        end
    end

    assign token_map       = chain_q;
    assign last_pixel_flag = {CLUSTERS{chain_q[PIXELS]}};

    // pixel bus, live view, charge injection, trigger outputs
    logic                bus_q;
    logic                live_q;
    logic                inject_q;
    logic [CLUSTERS-1:0] trig_n_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bus_q    <= 1'b0;
            live_q   <= 1'b0;
            inject_q <= 1'b0;
            trig_n_q <= '1;
        end else if (ce) begin
            bus_q    <= s_read & (|chain_q[PIXELS:1]);
            live_q   <= s_read & ~s_hold_cmd & ~s_self_en;
            inject_q <= write_rise;
            trig_n_q <= ~s_over;
        end
    end

    assign bus_connect       = bus_q;
    assign live_view         = live_q;
    assign inject_strobe     = inject_q;
    assign cluster_trigger_n = trig_n_q;

    // peak detect and hold sequencing
    ptr_pkg::ptr_hold_state_t state_q;
    ptr_pkg::ptr_hold_state_t state_d;
    logic [15:0]              peak_cnt_q;
    wire                      start_peak = s_hold_cmd | (s_self_en & any_over);

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ptr_pkg::PTR_TRACK: begin
                if (start_peak)
                    state_d = ptr_pkg::PTR_PEAK;
            end
            ptr_pkg::PTR_PEAK: begin
                if (peak_cnt_q == PEAK_CYC)
                    state_d = ptr_pkg::PTR_HOLD;
            end
            ptr_pkg::PTR_HOLD: begin
                state_d = ptr_pkg::PTR_HOLD;
            end
            default: begin
                state_d = ptr_pkg::PTR_TRACK;
            end
        endcase
        if (s_clear)
            state_d = ptr_pkg::PTR_TRACK;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_q    <= ptr_pkg::PTR_TRACK;
            peak_cnt_q <= '0;
        end else if (ce) begin
            state_q    <= state_d;
            peak_cnt_q <= (state_d == ptr_pkg::PTR_PEAK &&
                           state_q == ptr_pkg::PTR_PEAK) ?
                          peak_cnt_q + 16'h0001 : 16'h0001;
        end
    end

    assign peak_detect = state_q[1];
    assign hold        = state_q[2];

    // settle timer: a sample is offered only after the output has settled
    logic [7:0] settle_q;
    logic       in_ready;
    wire        sel_event = s_read & clk_fall & ~s_reset;
    wire        push      = (settle_q == 8'h01) & in_ready &
                            (pos_q != '0) & (pos_q <= POS_LAST);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            settle_q <= '0;
        end else if (ce) begin
            if (sel_event)
                settle_q <= SETTLE_CYC;
            else if (settle_q > 8'h01)
                settle_q <= settle_q - 8'h01;
            else if (settle_q == 8'h01 && in_ready)
                settle_q <= '0;
        end
    end

    // two-entry buffer: output stage plus skid stage
    logic          out_v_q;
    logic [IW-1:0] out_q;
    logic          skid_v_q;
    logic [IW-1:0] skid_q;
    wire           pop      = out_v_q & sample_ready;
    wire           out_free = ~out_v_q | pop;

    assign in_ready = ~skid_v_q;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            out_v_q  <= 1'b0;
            out_q    <= '0;
            skid_v_q <= 1'b0;
            skid_q   <= '0;
        end else if (ce) begin
            if (skid_v_q && out_free) begin
                out_q    <= skid_q;
                out_v_q  <= 1'b1;
                skid_v_q <= 1'b0;
            end else if (push && out_free) begin
                out_q   <= pos_q;
                out_v_q <= 1'b1;
            end else if (push) begin
                skid_q   <= pos_q;
                skid_v_q <= 1'b1;
            end else if (pop) begin
                out_v_q <= 1'b0;
            end
        end
    end

    assign sample_valid = out_v_q;
    assign sample_index = out_q;

    AST_HOLD_CMD_ENTER: assert property (@(posedge clk_sys) disable iff (srst)
        ce && state_q == ptr_pkg::PTR_TRACK && s_hold_cmd && !s_clear
        |=> state_q == ptr_pkg::PTR_PEAK)
        else $error("hold command did not start peak detect");

    AST_SELF_TRIG_ENTER: assert property (@(posedge clk_sys) disable iff (srst)
        ce && state_q == ptr_pkg::PTR_TRACK && !s_clear && !s_hold_cmd
        && s_self_en && any_over
        |=> peak_detect && !hold)
        else $error("enabled self trigger did not start peak detect");

    AST_CLEAR_TRACK: assert property (@(posedge clk_sys) disable iff (srst)
        ce && s_clear |=> !peak_detect && !hold)
        else $error("memory clear did not return to track");

    AST_RESET_TOKEN: assert property (@(posedge clk_sys) disable iff (srst)
        ce && s_reset |=> token_map == TOKEN_LOAD && pos_q == '0)
        else $error("reset did not load a single token");

    AST_SHIFT_ONE: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !s_reset && clk_fall && !s_fill
        |=> token_map == {$past(chain_q[PIXELS-1:0]), 1'b0})
        else $error("chain did not advance by one element");

    AST_FILL_PUSH: assert property (@(posedge clk_sys) disable iff (srst)
        ce && !s_reset && clk_fall && s_fill
        |=> token_map[0] && token_map[1] == $past(chain_q[0]))
        else $error("fill clock did not push a token");

    AST_BUS_CONNECT: assert property (@(posedge clk_sys) disable iff (srst)
        ce ##1 ce && $past(s_read) && $past(|chain_q[PIXELS:1])
        |-> bus_connect)
        else $error("token pixel not connected while read high");

    AST_INJECT: assert property (@(posedge clk_sys) disable iff (srst)
        ce && write_rise |=> inject_strobe ##1 !inject_strobe)
        else $error("write edge did not give one inject strobe");

    AST_LIVE: assert property (@(posedge clk_sys) disable iff (srst)
        ce && s_read && !s_hold_cmd && !s_self_en |=> live_view)
        else $error("live view missing");

    AST_TRIG_OUT: assert property (@(posedge clk_sys) disable iff (srst)
        ce |=> cluster_trigger_n == ~$past(s_over))
        else $error("cluster trigger output does not follow event");

    AST_SETTLE_WAIT: assert property (@(posedge clk_sys) disable iff (srst)
        ce && sel_event |=> !push [*2])
        else $error("sample offered before output settled");

    AST_BUF_STALL: assert property (@(posedge clk_sys) disable iff (srst)
        sample_valid && !sample_ready
        |=> sample_valid && $stable(sample_index))
        else $error("stalled sample lost or changed");

endmodule : ptr_readout_ctrl

// ### testbench/ptr_sample_sink.sv
// sample consumer model: takes pixel samples in order, may stall
`timescale 1ns/100ps
module ptr_sample_sink #(
    parameter int IW = 3
) (
    clk_sys,
    srst,
    stall,
    sample_valid,
    sample_index,
    sample_ready,
    got_count,
    order_bad
);
    input  wire logic          clk_sys;
    input  wire logic          srst;
    input  wire logic          stall;
    input  wire logic          sample_valid;
    input  wire logic [IW-1:0] sample_index;
    output logic               sample_ready;
    output int                 got_count;
    output logic               order_bad;

    assign sample_ready = !stall;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            got_count <= 0;
            order_bad <= 1'b0;
        end else if (sample_valid && sample_ready) begin
            got_count <= got_count + 1;
            // one sample per selected pixel, in chain order
            if (sample_index !== IW'(got_count + 1)) begin
                order_bad <= 1'b1;
            end
        end
    end
endmodule : ptr_sample_sink

// ### testbench/tb.sv
// self-checking bench for the pixel token readout control
`timescale 1ns/100ps
module tb;
    localparam int PX = 6;
    localparam int IW = $clog2(PX + 2);
    logic clk_sys = 1'b0;
    logic srst, chain_reset, reg_clk, read, write, multi_token_fill;
    logic peak_hold_cmd, self_trigger_enable, analog_memory_clear, stall;
    logic ce;
    logic [7:0] cot, cluster_trigger_n, last_pixel_flag;
    logic [PX:0] token_map;
    logic bus_connect, live_view, inject_strobe, peak_detect, hold;
    logic sample_valid, sample_ready, order_bad;
    logic [IW-1:0] sample_index;
    int got_count, err_count = 0, cmp_count = 0, n;

    always #20 clk_sys = ~clk_sys;

    ptr_readout_ctrl #(.CLUSTERS(8), .PIXELS(PX)) u_dut (
        .clk_sys(clk_sys), .srst(srst), .ce(ce),
        .chain_reset(chain_reset), .reg_clk(reg_clk), .read(read),
        .write(write), .multi_token_fill(multi_token_fill),
        .peak_hold_cmd(peak_hold_cmd),
        .self_trigger_enable(self_trigger_enable),
        .analog_memory_clear(analog_memory_clear),
        .cluster_over_threshold(cot),
        .cluster_trigger_n(cluster_trigger_n),
        .last_pixel_flag(last_pixel_flag), .token_map(token_map),
        .bus_connect(bus_connect), .live_view(live_view),
        .inject_strobe(inject_strobe), .peak_detect(peak_detect),
        .hold(hold), .sample_valid(sample_valid),
        .sample_index(sample_index), .sample_ready(sample_ready));

    ptr_sample_sink #(.IW(IW)) u_sink (
        .clk_sys(clk_sys), .srst(srst), .stall(stall),
        .sample_valid(sample_valid), .sample_index(sample_index),
        .sample_ready(sample_ready), .got_count(got_count),
        .order_bad(order_bad));

    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    task automatic clk_pulse();
        reg_clk <= 1'b1;
        step(4);
        reg_clk <= 1'b0;
        step(4);
    endtask : clk_pulse

    task automatic rst_chain();
        chain_reset <= 1'b1;
        step(4);
        clk_pulse();
        chain_reset <= 1'b0;
        step(4);
    endtask : rst_chain

    task automatic clear_mem();
        analog_memory_clear <= 1'b1;
        step(5);
        analog_memory_clear <= 1'b0;
        step(5);
    endtask : clear_mem

    initial begin
        {chain_reset, reg_clk, read, write, multi_token_fill} = '0;
        {peak_hold_cmd, self_trigger_enable, analog_memory_clear} = '0;
        stall = 1'b0;
        ce = 1'b1;
        cot = '0;
        srst = 1'b1;
        step(8);
        srst <= 1'b0;
        step(1);
        rst_chain();
        chk(token_map, 16'h0001);
        chk(cluster_trigger_n, 16'h00ff);
        $display("test reset done");
        read <= 1'b1;
        stall <= 1'b1;
        for (int k = 1; k <= PX; k++) begin
            if (k == 3) begin
                chk(sample_valid, 16'h0001);
                chk(sample_index, 16'h0001);
                stall <= 1'b0;
                step(2);
            end
            clk_pulse();
            chk(token_map, 16'(1 << k));
            chk(bus_connect, 16'h0001);
        end
        step(6);
        chk(last_pixel_flag, 16'h00ff);
        chk(16'(got_count), 16'(PX));
        chk(order_bad, 16'h0000);
        read <= 1'b0;
        step(5);
        chk(bus_connect, 16'h0000);
        $display("test readout done");
        rst_chain();
        multi_token_fill <= 1'b1;
        clk_pulse();
        clk_pulse();
        multi_token_fill <= 1'b0;
        chk(token_map, 16'h0007);
        write <= 1'b1;
        n = 0;
        repeat (8) begin
            step(1);
            if (inject_strobe === 1'b1) n++;
        end
        write <= 1'b0;
        chk(16'(n), 16'h0001);
        rst_chain();
        chk(token_map, 16'h0001);
        $display("test multi token done");
        peak_hold_cmd <= 1'b1;
        n = 0;
        while (peak_detect !== 1'b1 && n < 10) begin
            step(1);
            n++;
        end
        chk(peak_detect, 16'h0001);
        n = 0;
        while (hold !== 1'b1 && n < 400) begin
            step(1);
            n++;
        end
        if (n == 400) err_count++;
        chk(16'(n), 16'h00fa);
        chk(peak_detect, 16'h0000);
        peak_hold_cmd <= 1'b0;
        clear_mem();
        chk(hold, 16'h0000);
        cot <= 8'h04;
        step(5);
        chk(cluster_trigger_n, 16'h00fb);
        chk(peak_detect, 16'h0000);
        self_trigger_enable <= 1'b1;
        step(5);
        chk(peak_detect, 16'h0001);
        cot <= 8'h00;
        self_trigger_enable <= 1'b0;
        clear_mem();
        chk(peak_detect, 16'h0000);
        $display("test peak hold done");
        step(2500);
        read <= 1'b1;
        step(5);
        chk(live_view, 16'h0001);
        self_trigger_enable <= 1'b1;
        step(5);
        chk(live_view, 16'h0000);
        // clock enable low must freeze the pin path
        ce <= 1'b0;
        self_trigger_enable <= 1'b0;
        step(5);
        chk(live_view, 16'h0000);
        ce <= 1'b1;
        step(5);
        chk(live_view, 16'h0001);
        read <= 1'b0;
        step(5);
        $display("test live view done");
        wrap_up();
    end
endmodule : tb
